// file: common/rtcpc_defs.vh
// Register map, field widths and reset values of the RTC timekeeping core
// Included by the core and its register store; definitions only
`ifndef RTCPC_DEFS_VH
`define RTCPC_DEFS_VH
`define RTCPC_A_PSCH      8'h08
`define RTCPC_A_PSCL      8'h0c
`define RTCPC_A_DIVH      8'h10
`define RTCPC_A_DIVL      8'h14
`define RTCPC_A_CNTH      8'h18
`define RTCPC_A_CNTL      8'h1c
`define RTCPC_A_ALMH      8'h20
`define RTCPC_A_ALML      8'h24
`define RTCPC_A_STAT      8'h28
`define RTCPC_A_MASK      8'h2c
`define RTCPC_PSC_RST     20'h08000
`define RTCPC_DIV_RST     20'h08000
`define RTCPC_HALF_ONES   16'hffff
`define RTCPC_HALF_ZERO   16'h0000
`define RTCPC_WORD_ZERO   32'h00000000
`define RTCPC_EVT_SEC     0
`define RTCPC_EVT_ALM     1
`define RTCPC_EVT_W       2
`endif

// file: rtl/rtcpc_half_store.v
// Two 16-bit halves of a 32-bit value with registered read port
// Assumes single clock, one write strobe per half
`include "rtcpc_defs.vh"
module rtcpc_half_store #(
    parameter [31:0] RST_VAL = 32'hffffffff
) (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        ce,
    input  wire        wr_hi,
    input  wire        wr_lo,
    input  wire [15:0] wdata,
    output reg  [31:0] value_r
);
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            value_r <= RST_VAL;
        else if (ce)
        begin
            if (wr_hi)
                value_r[31:16] <= wdata;
            if (wr_lo)
                value_r[15:0] <= wdata;
        end
    end
endmodule

// file: rtl/rtcpc_core.v
// RTC timekeeping core: prescaler, countdown divider, seconds count, alarm
// Assumes clk_sys is the rtc source clock; register port is synchronous
//
// Contract
// - Each register answers alike to half-word or word access; low 16 bits.
// - Prescale value is 20 bits; low half written at PSCL, top four at PSCH.
// - Seconds tick rate is source clock over prescale value plus one.
// - Divider count is readable: bits 19:16 high, 15:0 low register.
// - Divider reloads whenever software writes prescale or count.
// - Seconds count is 32 bits, read-write in two halves, reset zero.
// - Alarm compare is 32 bits, written in two halves, reset all ones.
// - Divider reaching zero sets the second event flag and advances the count; a reload write suppresses it.
`include "rtcpc_defs.vh"
module rtcpc_core #(
    parameter PSC_W = 20
) (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        ce,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr_stb,
    input  wire        rd_stb,
    output reg  [31:0] rdata_r,
    output reg         seconds_tick_clock_r,
    output reg         alarm_evt_r,
    output reg         irq_r
);
    reg  [PSC_W-1:0]        prescale_value_r;
    reg  [PSC_W-1:0]        div_r;
    reg  [31:0]             seconds_count_r;
    reg  [`RTCPC_EVT_W-1:0] status_r;
    reg  [`RTCPC_EVT_W-1:0] mask_r;
    reg  [31:0]             seconds_count_nxt;
    reg  [31:0]             rdata_nxt;
    wire [31:0]             alarm_compare;
    wire                    wr_psch;
    wire                    wr_pscl;
    wire                    wr_cnth;
    wire                    wr_cntl;
    wire                    reload;
    wire                    tick;
    wire                    alarm_hit;
    wire [`RTCPC_EVT_W-1:0] evt;
    wire [`RTCPC_EVT_W-1:0] status_nxt;

    function hit;
        input [7:0] a;
        input [7:0] want;
        begin
            hit = (a == want);
        end
    endfunction

    // Only the low half of wdata is used, so half-word and word match
    assign wr_psch = wr_stb && hit(addr, `RTCPC_A_PSCH);
    assign wr_pscl = wr_stb && hit(addr, `RTCPC_A_PSCL);
    assign wr_cnth = wr_stb && hit(addr, `RTCPC_A_CNTH);
    assign wr_cntl = wr_stb && hit(addr, `RTCPC_A_CNTL);

    rtcpc_half_store #(
        .RST_VAL ({`RTCPC_HALF_ONES, `RTCPC_HALF_ONES})
    ) u_alarm (
        .clk_sys (clk_sys),
        .rst     (rst),
        .ce      (ce),
        .wr_hi   (wr_stb && hit(addr, `RTCPC_A_ALMH)),
        .wr_lo   (wr_stb && hit(addr, `RTCPC_A_ALML)),
        .wdata   (wdata[15:0]),
        .value_r (alarm_compare)
    );

    // Count write is also a reload so the new second starts whole
    assign reload = wr_psch || wr_pscl || wr_cnth || wr_cntl;
    assign tick = !reload && (div_r == {PSC_W{1'b0}});

    always @*
    begin
        seconds_count_nxt = seconds_count_r;
        if (tick)
            seconds_count_nxt = seconds_count_r + 32'h00000001;
        if (wr_cnth)
            seconds_count_nxt[31:16] = wdata[15:0];
        if (wr_cntl)
            seconds_count_nxt[15:0] = wdata[15:0];
    end

    // Compare against the new count so a match is seen once on arrival
    assign alarm_hit = (seconds_count_nxt != seconds_count_r) &&
                       (seconds_count_nxt == alarm_compare);
    assign evt = {alarm_hit, tick};
    // Set wins over the write-one clear in the same cycle
    assign status_nxt = (status_r & ~((wr_stb && hit(addr, `RTCPC_A_STAT)) ?
                        wdata[`RTCPC_EVT_W-1:0] : {`RTCPC_EVT_W{1'b0}}))
                        | evt;

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prescale_value_r     <= `RTCPC_PSC_RST;
            div_r                <= `RTCPC_DIV_RST;
            seconds_count_r      <= `RTCPC_WORD_ZERO;
            status_r             <= {`RTCPC_EVT_W{1'b0}};
            mask_r               <= {`RTCPC_EVT_W{1'b0}};
            seconds_tick_clock_r <= 1'b0;
            alarm_evt_r          <= 1'b0;
            irq_r                <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_psch)
                prescale_value_r[PSC_W-1:16] <= wdata[PSC_W-17:0];
            if (wr_pscl)
                prescale_value_r[15:0] <= wdata[15:0];
            if (reload)
            begin
                // New prescale takes effect at once on reload
                div_r <= prescale_value_r;
                if (wr_psch)
                    div_r[PSC_W-1:16] <= wdata[PSC_W-17:0];
                if (wr_pscl)
                    div_r[15:0] <= wdata[15:0];
            end
            else if (tick)
                div_r <= prescale_value_r;
            else
                div_r <= div_r - {{(PSC_W-1){1'b0}}, 1'b1};
            seconds_count_r      <= seconds_count_nxt;
            status_r             <= status_nxt;
            if (wr_stb && hit(addr, `RTCPC_A_MASK))
                mask_r <= wdata[`RTCPC_EVT_W-1:0];
            seconds_tick_clock_r <= tick;
            alarm_evt_r          <= alarm_hit;
            irq_r                <= |(status_nxt & mask_r);
        end
    end

    // Unmapped and write-only addresses read zero; keeps upper bits zero
    always @*
    begin
        rdata_nxt = `RTCPC_WORD_ZERO;
        if (hit(addr, `RTCPC_A_DIVH))
            rdata_nxt[PSC_W-17:0] = div_r[PSC_W-1:16];
        else if (hit(addr, `RTCPC_A_DIVL))
            rdata_nxt[15:0] = div_r[15:0];
        else if (hit(addr, `RTCPC_A_CNTH))
            rdata_nxt[15:0] = seconds_count_r[31:16];
        else if (hit(addr, `RTCPC_A_CNTL))
            rdata_nxt[15:0] = seconds_count_r[15:0];
        else if (hit(addr, `RTCPC_A_STAT))
            rdata_nxt[`RTCPC_EVT_W-1:0] = status_r;
        else if (hit(addr, `RTCPC_A_MASK))
            rdata_nxt[`RTCPC_EVT_W-1:0] = mask_r;
    end

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rdata_r <= `RTCPC_WORD_ZERO;
        else if (ce)
            rdata_r <= rd_stb ? rdata_nxt : `RTCPC_WORD_ZERO;
    end
endmodule

// file: dv/rtcpc_assertions.sv
// Port checker for the RTC timekeeping core
// Assumes ce held high and a prescale value of two or more
module rtcpc_assertions (
    input logic        clk_sys,
    input logic        rst,
    input logic [7:0]  addr,
    input logic [31:0] wdata,
    input logic        wr_stb,
    input logic        rd_stb,
    input logic [31:0] rdata_r,
    input logic        seconds_tick_clock_r,
    input logic        alarm_evt_r,
    input logic        irq_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_cnt_wr; wr_stb && addr == 8'h1c; endsequence
    sequence s_cnt_rd; rd_stb && addr == 8'h1c; endsequence
    a_read_slot: assert property (rdata_r != 0 |-> $past(rd_stb))
        else $error("read data outside its slot");
    a_wo_read: assert property (rd_stb && (addr == 8'h0c || addr == 8'h20
        || addr == 8'h24 || addr > 8'h2c) |=> rdata_r == 0)
        else $error("write-only or unmapped read not zero");
    a_divh_width: assert property (rd_stb && addr == 8'h10
        |=> rdata_r[31:4] == 0)
        else $error("divider high wider than four bits");
    a_cnt_back: assert property (s_cnt_wr ##2 s_cnt_rd
        |=> rdata_r == {16'h0, $past(wdata[15:0], 3)})
        else $error("count low readback wrong");
    // A reload write to 0x0c, 0x18 or 0x1c keeps the tick low for the next two cycles
    a_reload_quiet: assert property (wr_stb && (addr == 8'h0c
        || addr == 8'h18 || addr == 8'h1c) |=> !seconds_tick_clock_r [*2])
        else $error("tick too soon after reload");
    a_tick_pulse: assert property (seconds_tick_clock_r
        |=> !seconds_tick_clock_r)
        else $error("tick longer than one cycle");
    a_alarm_pulse: assert property (alarm_evt_r |=> !alarm_evt_r)
        else $error("alarm pulse longer than one cycle");
    // The clear write and the falling edge of irq_r share one clock edge
    a_irq_clear: assert property ($fell(irq_r) |-> $past(wr_stb))
        else $error("interrupt dropped without a write");
endmodule

// file: dv/rtcpc_core_test.sv
// Self-checking bench for the RTC timekeeping core
// Assumes the core and its alarm half store are the only design modules; ce stays high except for 30 cycles in the freeze test
module rtcpc_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1, ce = 1, wr_stb = 0, rd_stb = 0, rd_p = 0;
    logic [7:0] addr = 0;
    logic [31:0] wdata = 0, rdata_r, exp_q[$];
    logic seconds_tick_clock_r, alarm_evt_r, irq_r;
    int mismatches = 0, n_tests = 0, p, n;
    rtcpc_core i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_r(rdata_r),
        .seconds_tick_clock_r(seconds_tick_clock_r),
        .alarm_evt_r(alarm_evt_r), .irq_r(irq_r));
    initial forever #10 clk_sys = ~clk_sys;
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (e !== g)
        begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= {16'h0, d};
        wr_stb <= 1;
        @(posedge clk_sys);
        wr_stb <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1;
        @(posedge clk_sys);
        rd_stb <= 0;
    endtask
    // Bounded wait on the tick or alarm pulse, sampled mid-cycle
    task wtick(input logic alm);
        for (n = 0; n < 200 && !(alm ? alarm_evt_r : seconds_tick_clock_r);
             n++) @(negedge clk_sys);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk_sys) rd_p <= rd_stb;
    always @(negedge clk_sys) if (rd_p) chk("rdata", exp_q.pop_front(), rdata_r);
    // Whole run is a few hundred cycles; 10000 leaves ample margin
    initial
    begin
        #200000;
        mismatches++;
        give_verdict;
    end
    initial
    begin
        void'($urandom(17786));
        p = 2 + $urandom % 8;
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        rd(8'h10, 0);
        rd(8'h18, 0);
        rd(8'h0c, 0);
        rd(8'h20, 0);
        rd(8'h30, 0);
        $display("reset test done");
        wr(8'h08, 0);
        wr(8'h0c, p[15:0]);
        rd(8'h14, p - 1);
        wtick(0);
        @(negedge clk_sys);
        wtick(0);
        chk("tick period", p + 1, n + 1);
        $display("prescale test done");
        wr(8'h18, 0);
        wr(8'h1c, 0);
        rd(8'h1c, 0);
        repeat (3)
        begin
            wtick(0);
            @(negedge clk_sys);
        end
        rd(8'h1c, 3);
        $display("count test done");
        wr(8'h20, 0);
        wr(8'h24, 8);
        wr(8'h2c, 2);
        wtick(1);
        chk("irq", 1, irq_r);
        rd(8'h1c, 8);
        wr(8'h28, 2);
        repeat (2) @(negedge clk_sys);
        chk("irq", 0, irq_r);
        rd(8'h28, 1);
        rd(8'h2c, 2);
        $display("alarm test done");
        // Low ce must hold the divider and count through many tick periods
        wr(8'h1c, 5);
        @(posedge clk_sys);
        ce <= 0;
        repeat (30) @(posedge clk_sys);
        ce <= 1;
        rd(8'h1c, 5);
        $display("freeze test done");
        give_verdict;
    end
endmodule
bind rtcpc_core rtcpc_assertions i_chk (.clk_sys(clk_sys), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata_r(rdata_r), .seconds_tick_clock_r(seconds_tick_clock_r),
    .alarm_evt_r(alarm_evt_r), .irq_r(irq_r));
